// File: core/home_pkg.sv
package home_pkg;
  // widths of the position, speed, time, table and code paths
  localparam int POS_W = 32;
  localparam int SPD_W = 16;
  localparam int TIME_W = 16;
  localparam int TABLE_W = 8;
  localparam int CODE_W = 8;
  // parameter encodings
  localparam logic [3:0] METHOD_DOG_CRADLE = 4'ha;
  localparam logic HOME_DIR_FWD = 1'b0;
  localparam logic DISPLAY_ROLL_FEED = 1'b1;
  localparam logic SYSTEM_INCREMENTAL = 1'b0;
  localparam logic SYSTEM_ABSOLUTE = 1'b1;
  localparam logic [CODE_W-1:0] ALARM_NONE = 8'h00;
  localparam logic [CODE_W-1:0] ALARM_NO_DOG = 8'h90;
  localparam logic [TABLE_W-1:0] TABLE_NONE = 8'h00;
  // clock and start lead time
  localparam int CLK_HZ = 20_000_000;
  localparam int START_LEAD_US = 10;
  localparam int START_LEAD_CYC = (START_LEAD_US * (CLK_HZ / 1_000_000) < 1) ? 1 :
    START_LEAD_US * (CLK_HZ / 1_000_000);
  localparam int LEAD_W = 16;
  // wishbone byte offsets of the controller registers
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_CFG = 4'h4;
  localparam logic [3:0] OFS_STATUS = 4'h8;
  // control register fields
  localparam int CTRL_AUTO_MAN = 0;
  localparam int CTRL_TABLE_LO = 1;
  localparam int CTRL_SRC = 9;
  localparam int CTRL_FWD_START = 10;
  localparam int CTRL_REV_START = 11;
  // configuration register fields
  localparam int CFG_METHOD_LO = 0;
  localparam int CFG_DIR = 4;
  localparam int CFG_DISPLAY = 5;
  localparam int CFG_SYSTEM = 6;
  // status register fields
  localparam int ST_HOME_EST = 0;
  localparam int ST_BUSY = 1;
  localparam int ST_ALARM = 2;
  localparam int ST_REFUSED = 3;
  localparam int ST_CODE_LO = 8;
endpackage

// File: core/station_link_if.sv
`timescale 1ns/1ns
interface station_link_if;
  import home_pkg::*;
  // master to driver: remote input bits and parameters
  logic auto_manual_select;
  logic [TABLE_W-1:0] table_select;
  logic pos_speed_source_select;
  logic forward_rotation_start;
  logic reverse_rotation_start;
  logic [3:0] home_method_param;
  logic home_direction_param;
  logic display_select_param;
  logic position_system_param;
  // driver to master: status bits
  logic home_established;
  logic busy;
  logic alarm;
  logic [CODE_W-1:0] alarm_code;
  logic refused;
  modport dev (
    input auto_manual_select, table_select, pos_speed_source_select,
    input forward_rotation_start, reverse_rotation_start,
    input home_method_param, home_direction_param, display_select_param, position_system_param,
    output home_established, busy, alarm, alarm_code, refused
  );
  modport host (
    output auto_manual_select, table_select, pos_speed_source_select,
    output forward_rotation_start, reverse_rotation_start,
    output home_method_param, home_direction_param, display_select_param, position_system_param,
    input home_established, busy, alarm, alarm_code, refused
  );
endinterface

// File: core/sync2.sv
`timescale 1ns/1ns
module sync2 #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_r;
  // two stages; only the second stage is read outside
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta_r <= '0;
      q_o <= '0;
    end
    else
    begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end
endmodule

// File: core/home_return_sequencer.sv
// Our own choices: register access over Wishbone and the address map.
`timescale 1ns/1ns
module home_return_sequencer
  import home_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  station_link_if.dev link,
  input wire logic dog_i,
  input wire logic fwd_end_i,
  input wire logic rev_end_i,
  input wire logic zphase_i,
  input wire logic step_i,
  input wire logic step_dir_i,
  input wire logic [SPD_W-1:0] home_speed_i,
  input wire logic [SPD_W-1:0] creep_speed_i,
  input wire logic [POS_W-1:0] home_shift_i,
  input wire logic [POS_W-1:0] home_pos_value_i,
  input wire logic [TIME_W-1:0] pt1_accel_i,
  input wire logic [TIME_W-1:0] pt1_decel_i,
  input wire logic signed [POS_W-1:0] pos_min_i,
  input wire logic signed [POS_W-1:0] pos_max_i,
  input wire logic soft_limit_en_i,
  output logic move_o,
  output logic dir_o,
  output logic [SPD_W-1:0] speed_o,
  output logic [TIME_W-1:0] accel_o,
  output logic [TIME_W-1:0] decel_o,
  output logic soft_limit_en_o,
  output logic [POS_W-1:0] cur_pos_o,
  output logic [POS_W-1:0] disp_cur_pos_o,
  output logic [POS_W-1:0] disp_cmd_pos_o
);
  typedef enum logic [3:0] {
    S_IDLE, S_BACKOFF, S_SEEK, S_RETREAT, S_RETREAT_PAST, S_HALT, S_CREEP, S_SHIFT, S_AUTO, S_ALARM
  } state_t;

  state_t state_r, state_nxt;
  logic dog_s, fwd_end_s, rev_end_s, z_s, z_d_r;
  logic fwd_start_d_r, rev_start_d_r;
  logic mode_ok, fwd_rise, rev_rise, start_home, start_auto, auto_in_range;
  logic home_fwd, home_end, away_end, z_rise, finish, auto_at_home;
  logic home_est_r, alarm_r, refused_r, done_nxt;
  logic [CODE_W-1:0] alarm_code_r;
  logic [POS_W-1:0] shift_cnt_r;
  logic [POS_W-1:0] step_delta;

  // pins from the machine are asynchronous to clk_i
  sync2 #(.W(4)) pin_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({dog_i, fwd_end_i, rev_end_i, zphase_i}),
    .q_o({dog_s, fwd_end_s, rev_end_s, z_s})
  );

  // start edges and mode qualification
  assign mode_ok = link.auto_manual_select && (link.table_select == TABLE_NONE);
  assign fwd_rise = link.forward_rotation_start && !fwd_start_d_r;
  assign rev_rise = link.reverse_rotation_start && !rev_start_d_r;
  assign start_home = fwd_rise && mode_ok && (link.home_method_param == METHOD_DOG_CRADLE);
  assign auto_in_range = ($signed(cur_pos_o) >= pos_min_i) && ($signed(cur_pos_o) <= pos_max_i);
  assign start_auto = rev_rise && mode_ok && home_est_r;
  assign home_fwd = (link.home_direction_param == HOME_DIR_FWD);
  assign home_end = home_fwd ? fwd_end_s : rev_end_s;
  assign away_end = home_fwd ? rev_end_s : fwd_end_s;
  assign z_rise = z_s && !z_d_r;
  assign auto_at_home = (cur_pos_o == home_pos_value_i);
  assign step_delta = step_dir_i ? {{(POS_W-1){1'b0}}, 1'b1} : {POS_W{1'b1}};

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      fwd_start_d_r <= 1'b0;
      rev_start_d_r <= 1'b0;
      z_d_r <= 1'b0;
    end
    else
    begin
      fwd_start_d_r <= link.forward_rotation_start;
      rev_start_d_r <= link.reverse_rotation_start;
      z_d_r <= z_s;
    end
  end

  // sequencing of the return; a new start is only taken from idle or alarm
  always_comb
  begin
    state_nxt = state_r;
    done_nxt = 1'b0;
    case (state_r)
      S_IDLE, S_ALARM:
      begin
        if (start_home)
          state_nxt = dog_s ? S_BACKOFF : S_SEEK;
        else if (start_auto && auto_in_range && !auto_at_home)
          state_nxt = S_AUTO;
      end
      S_BACKOFF:
        if (!dog_s)
          state_nxt = S_SEEK;
      S_SEEK:
      begin
        if (dog_s)
          state_nxt = S_CREEP;
        else if (home_end)
          state_nxt = S_RETREAT;
      end
      S_RETREAT:
      begin
        if (dog_s)
          state_nxt = S_RETREAT_PAST;
        else if (away_end)
          state_nxt = S_ALARM;
      end
      S_RETREAT_PAST:
        if (!dog_s)
          state_nxt = S_HALT;
      S_HALT:
        state_nxt = S_SEEK;
      S_CREEP:
        if (z_rise)
        begin
          state_nxt = (home_shift_i == '0) ? S_IDLE : S_SHIFT;
          done_nxt = (home_shift_i == '0);
        end
      S_SHIFT:
        if (step_i && (shift_cnt_r + 1'b1 >= home_shift_i))
        begin
          state_nxt = S_IDLE;
          done_nxt = 1'b1;
        end
      S_AUTO:
        if (auto_at_home)
          state_nxt = S_IDLE;
      default:
        state_nxt = S_IDLE;
    endcase
  end

  assign finish = done_nxt;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      state_r <= S_IDLE;
    else
      state_r <= state_nxt;
  end

  // steps travelled since the Z-phase pulse
  always_ff @(posedge clk_i)
  begin
    if (rst_i || state_r != S_SHIFT)
      shift_cnt_r <= '0;
    else if (step_i)
      shift_cnt_r <= shift_cnt_r + 1'b1;
  end

  // motion command registered from the next state so outputs come from flops
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      move_o <= 1'b0;
      dir_o <= 1'b0;
      speed_o <= '0;
      accel_o <= '0;
      decel_o <= '0;
    end
    else
    begin
      accel_o <= pt1_accel_i;
      decel_o <= pt1_decel_i;
      case (state_nxt)
        S_BACKOFF, S_RETREAT, S_RETREAT_PAST:
        begin
          move_o <= 1'b1;
          dir_o <= !home_fwd;
          speed_o <= home_speed_i;
        end
        S_SEEK:
        begin
          move_o <= 1'b1;
          dir_o <= home_fwd;
          speed_o <= home_speed_i;
        end
        S_CREEP, S_SHIFT:
        begin
          move_o <= 1'b1;
          dir_o <= home_fwd;
          speed_o <= creep_speed_i;
        end
        S_AUTO:
        begin
          move_o <= 1'b1;
          dir_o <= ($signed(home_pos_value_i) > $signed(cur_pos_o));
          speed_o <= home_speed_i;
        end
        default:
        begin
          move_o <= 1'b0;
          dir_o <= dir_o;
          speed_o <= '0;
        end
      endcase
    end
  end

  // software stroke limit is bypassed while any homing sequence runs
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      soft_limit_en_o <= 1'b0;
    else
      soft_limit_en_o <= soft_limit_en_i && (state_nxt == S_IDLE || state_nxt == S_ALARM);
  end

  // position tracking; completion overrides a step in the same cycle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cur_pos_o <= '0;
    else if (finish)
      cur_pos_o <= home_pos_value_i;
    else if (step_i)
      cur_pos_o <= cur_pos_o + step_delta;
  end

  // roll feed display restarts from zero at each accepted start
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      disp_cur_pos_o <= '0;
      disp_cmd_pos_o <= '0;
    end
    else if (link.display_select_param == DISPLAY_ROLL_FEED)
    begin
      if (start_home || start_auto)
      begin
        disp_cur_pos_o <= '0;
        disp_cmd_pos_o <= '0;
      end
      else if (step_i)
      begin
        disp_cur_pos_o <= disp_cur_pos_o + step_delta;
        disp_cmd_pos_o <= disp_cmd_pos_o + step_delta;
      end
    end
    else
    begin
      disp_cur_pos_o <= finish ? home_pos_value_i : (step_i ? cur_pos_o + step_delta : cur_pos_o);
      disp_cmd_pos_o <= finish ? home_pos_value_i : (step_i ? cur_pos_o + step_delta : cur_pos_o);
    end
  end

  // home established: by completion, or at once in an absolute system
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      home_est_r <= 1'b0;
    else if (finish || link.position_system_param == SYSTEM_ABSOLUTE)
      home_est_r <= 1'b1;
  end

  // alarm holds until the next qualified home start, whether or not the sequencer is free to take it
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      alarm_r <= 1'b0;
      alarm_code_r <= ALARM_NONE;
    end
    else if (state_nxt == S_ALARM && state_r != S_ALARM)
    begin
      alarm_r <= 1'b1;
      alarm_code_r <= ALARM_NO_DOG;
    end
    else if (start_home)
    begin
      alarm_r <= 1'b0;
      alarm_code_r <= ALARM_NONE;
    end
  end

  // one-cycle pulse when an auto homing start is refused
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      refused_r <= 1'b0;
    else
      refused_r <= rev_rise && mode_ok && (!home_est_r || !auto_in_range);
  end

  assign link.home_established = home_est_r;
  assign link.busy = (state_r != S_IDLE) && (state_r != S_ALARM);
  assign link.alarm = alarm_r;
  assign link.alarm_code = alarm_code_r;
  assign link.refused = refused_r;
endmodule

// File: core/master_station.sv
`timescale 1ns/1ns
module master_station
  import home_pkg::*;
#(
  parameter bit TWO_STATIONS = 1'b1,
  parameter int LEAD_CYC = START_LEAD_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  station_link_if.host link
);
  if (LEAD_CYC < 1 || LEAD_CYC >= (1 << LEAD_W))
  begin : g_lead_check
    $error("master_station: LEAD_CYC out of range");
  end

  logic [11:0] ctrl_r;
  logic [6:0] cfg_r;
  logic refused_seen_r;
  logic [LEAD_W-1:0] lead_r;
  logic wr, sel_chg;
  logic [31:0] status;

  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
  assign sel_chg = link.auto_manual_select != ctrl_r[CTRL_AUTO_MAN] ||
    link.table_select != ctrl_r[CTRL_TABLE_LO +: TABLE_W];
  assign status = {16'h0000, link.alarm_code, 4'h0, refused_seen_r, link.alarm, link.busy, link.home_established};

  // one ack per request, dropped in the following cycle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
  end

  // register writes; only the low byte lanes that carry fields are used
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_r <= '0;
      cfg_r <= '0;
    end
    else if (wr && wb_adr_i == OFS_CTRL)
    begin
      if (wb_sel_i[0])
        ctrl_r[7:0] <= wb_dat_i[7:0];
      if (wb_sel_i[1])
        ctrl_r[11:8] <= wb_dat_i[11:8];
    end
    else if (wr && wb_adr_i == OFS_CFG && wb_sel_i[0])
      cfg_r <= wb_dat_i[6:0];
  end

  // sticky refusal flag; a new refusal wins over a write-one clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      refused_seen_r <= 1'b0;
    else if (link.refused)
      refused_seen_r <= 1'b1;
    else if (wr && wb_adr_i == OFS_STATUS && wb_sel_i[0] && wb_dat_i[ST_REFUSED])
      refused_seen_r <= 1'b0;
  end

  // read mux; unmapped offsets read zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_dat_o <= '0;
    else if (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o)
    begin
      case (wb_adr_i)
        OFS_CTRL: wb_dat_o <= {20'h00000, ctrl_r};
        OFS_CFG: wb_dat_o <= {25'h0000000, cfg_r};
        OFS_STATUS: wb_dat_o <= status;
        default: wb_dat_o <= '0;
      endcase
    end
  end

  // a selection change holds the start bits off, covering the bus delay
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      lead_r <= '0;
    else if (sel_chg)
      lead_r <= LEAD_W'(LEAD_CYC);
    else if (lead_r != '0)
      lead_r <= lead_r - 1'b1;
  end

  // remote bits driven toward the driver
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      link.auto_manual_select <= 1'b0;
      link.table_select <= TABLE_NONE;
      link.pos_speed_source_select <= 1'b0;
      link.forward_rotation_start <= 1'b0;
      link.reverse_rotation_start <= 1'b0;
      link.home_method_param <= '0;
      link.home_direction_param <= HOME_DIR_FWD;
      link.display_select_param <= 1'b0;
      link.position_system_param <= SYSTEM_INCREMENTAL;
    end
    else
    begin
      link.auto_manual_select <= ctrl_r[CTRL_AUTO_MAN];
      link.table_select <= ctrl_r[CTRL_TABLE_LO +: TABLE_W];
      link.pos_speed_source_select <= ctrl_r[CTRL_SRC] || TWO_STATIONS;
      link.forward_rotation_start <= ctrl_r[CTRL_FWD_START] && (lead_r == '0) && !sel_chg;
      // automatic homing only once home is known, by a manual return or at once in an absolute system
      link.reverse_rotation_start <= ctrl_r[CTRL_REV_START] && (lead_r == '0) && !sel_chg &&
        link.home_established;
      link.home_method_param <= cfg_r[CFG_METHOD_LO +: 4];
      link.home_direction_param <= cfg_r[CFG_DIR];
      link.display_select_param <= cfg_r[CFG_DISPLAY];
      // roll feed forces the incremental system
      link.position_system_param <= cfg_r[CFG_SYSTEM] && (cfg_r[CFG_DISPLAY] != DISPLAY_ROLL_FEED);
    end
  end
endmodule

// File: verif/home_link_sva.sv
`timescale 1ns/1ns
module home_link_sva
  import home_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic auto_manual_select,
  input wire logic [TABLE_W-1:0] table_select,
  input wire logic forward_rotation_start,
  input wire logic reverse_rotation_start,
  input wire logic [3:0] home_method_param,
  input wire logic display_select_param,
  input wire logic position_system_param,
  input wire logic home_established,
  input wire logic busy,
  input wire logic alarm,
  input wire logic [CODE_W-1:0] alarm_code,
  input wire logic refused,
  input wire logic move_o,
  input wire logic [SPD_W-1:0] speed_o,
  input wire logic [SPD_W-1:0] home_speed_i,
  input wire logic [SPD_W-1:0] creep_speed_i,
  input wire logic [TIME_W-1:0] accel_o,
  input wire logic [TIME_W-1:0] pt1_accel_i,
  input wire logic soft_limit_en_o,
  input wire logic [POS_W-1:0] cur_pos_o,
  input wire logic [POS_W-1:0] home_pos_value_i,
  input wire logic signed [POS_W-1:0] pos_min_i,
  input wire logic signed [POS_W-1:0] pos_max_i,
  input wire logic [POS_W-1:0] disp_cur_pos_o,
  input wire logic [POS_W-1:0] disp_cmd_pos_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // start qualifiers shared by several properties
  logic mode_ok;
  logic outside;
  assign mode_ok = auto_manual_select && table_select == TABLE_NONE;
  assign outside = $signed(cur_pos_o) < pos_min_i || $signed(cur_pos_o) > pos_max_i;
  sequence s_home_req;
    $rose(forward_rotation_start) && mode_ok && home_method_param == METHOD_DOG_CRADLE && !busy;
  endsequence
  sequence s_auto_req;
    $rose(reverse_rotation_start) && mode_ok && !busy && !forward_rotation_start;
  endsequence
  sequence s_done;
    $fell(busy) && !alarm;
  endsequence
  // starts, motion and completion; busy is the sequencer's own state, which changes on the same edge as the outputs
  AST_HOME_START: assert property (s_home_req |=> busy)
    else $error("home start not taken");
  AST_MODE_GATE: assert property (($rose(forward_rotation_start) || $rose(reverse_rotation_start)) && !mode_ok && !busy |=> !busy)
    else $error("start taken outside home mode");
  AST_SPEED: assert property (move_o && busy |-> speed_o == home_speed_i || speed_o == creep_speed_i)
    else $error("travel speed not from parameters");
  AST_PT1_RATES: assert property (busy |-> accel_o == $past(pt1_accel_i))
    else $error("ramp not from first table entry");
  AST_SOFT_LIMIT: assert property (busy && $past(busy) |-> !soft_limit_en_o)
    else $error("software limit active during return");
  AST_NO_DOG_ALARM: assert property ($rose(alarm) |-> alarm_code == ALARM_NO_DOG && !busy && !move_o)
    else $error("alarm without stop or code");
  AST_HOME_LOAD: assert property (s_done |-> cur_pos_o == home_pos_value_i && home_established && !move_o)
    else $error("completion without home load");
  AST_AUTO_REFUSE: assert property (s_auto_req ##0 (home_established && outside) |=> refused && !busy)
    else $error("out of range auto homing not refused");
  AST_ABS_HOME: assert property (position_system_param |-> ##[1:2] home_established)
    else $error("absolute system lacks home");
  AST_ROLL_INCR: assert property (display_select_param |-> !position_system_param)
    else $error("roll feed with absolute system");
  AST_ROLL_ZERO: assert property ($rose(busy) && display_select_param |-> disp_cur_pos_o == '0 && disp_cmd_pos_o == '0)
    else $error("roll feed display not zeroed");
  AST_LEAD: assert property ($changed(table_select) || $changed(auto_manual_select) |-> !$rose(forward_rotation_start))
    else $error("start with mode change");
endmodule

// File: verif/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  import home_pkg::*;
  localparam logic [31:0] MODE = 32'h0000_0201; // auto mode, tables zero, register source
  localparam logic [31:0] FWD = MODE | (32'h1 << CTRL_FWD_START);
  localparam logic [31:0] REV = MODE | (32'h1 << CTRL_REV_START);
  localparam logic [31:0] HOME_VAL = 32'h0000_0064;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
  logic [3:0] adr = 4'h0, sel = 4'hf;
  logic [31:0] dat_w = 32'h0, dat_r, q;
  logic dog = 1'b0, fwd_end = 1'b0, rev_end = 1'b0, zph = 1'b0, step = 1'b0, step_dir = 1'b0;
  logic plant_on = 1'b0, nudge = 1'b0, lim_en = 1'b1, move, dir, slim;
  logic [1:0] ph = 2'h0;
  logic [SPD_W-1:0] hspd = 16'h0120, cspd = 16'h0010, spd;
  logic [TIME_W-1:0] acc = 16'h0033, dec = 16'h0044, acc_o, dec_o;
  logic signed [POS_W-1:0] pmin = 32'shffff_fc18, pmax = 32'sh0000_03e8;
  logic [POS_W-1:0] cur, dcur, dcmd;
  int errors = 0, tests_run = 0, n_steps = 0, halts = 0;

  station_link_if lnk ();
  master_station #(.TWO_STATIONS(1'b1), .LEAD_CYC(2)) master_station_inst (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w),
    .wb_dat_o(dat_r), .wb_ack_o(ack), .link(lnk.host));
  home_return_sequencer home_return_sequencer_inst (.clk_i(clk_i), .rst_i(rst_i), .link(lnk.dev),
    .dog_i(dog), .fwd_end_i(fwd_end), .rev_end_i(rev_end), .zphase_i(zph), .step_i(step), .step_dir_i(step_dir),
    .home_speed_i(hspd), .creep_speed_i(cspd), .home_shift_i(32'h0000_0003), .home_pos_value_i(HOME_VAL),
    .pt1_accel_i(acc), .pt1_decel_i(dec), .pos_min_i(pmin), .pos_max_i(pmax), .soft_limit_en_i(lim_en),
    .move_o(move), .dir_o(dir), .speed_o(spd), .accel_o(acc_o), .decel_o(dec_o), .soft_limit_en_o(slim),
    .cur_pos_o(cur), .disp_cur_pos_o(dcur), .disp_cmd_pos_o(dcmd));
  home_link_sva home_link_sva_inst (.clk_i(clk_i), .rst_i(rst_i), .auto_manual_select(lnk.auto_manual_select),
    .table_select(lnk.table_select), .forward_rotation_start(lnk.forward_rotation_start),
    .reverse_rotation_start(lnk.reverse_rotation_start), .home_method_param(lnk.home_method_param),
    .display_select_param(lnk.display_select_param), .position_system_param(lnk.position_system_param),
    .home_established(lnk.home_established), .busy(lnk.busy), .alarm(lnk.alarm), .alarm_code(lnk.alarm_code),
    .refused(lnk.refused), .move_o(move), .speed_o(spd), .home_speed_i(hspd), .creep_speed_i(cspd),
    .accel_o(acc_o), .pt1_accel_i(acc), .soft_limit_en_o(slim), .cur_pos_o(cur), .home_pos_value_i(HOME_VAL),
    .pos_min_i(pmin), .pos_max_i(pmax), .disp_cur_pos_o(dcur), .disp_cmd_pos_o(dcmd));

  always #25 clk_i = ~clk_i;

  // encoder stand-in: a step every fourth cycle, so a stop lands before the next step
  always @(posedge clk_i)
  begin
    ph <= ph + 2'h1;
    step <= (ph == 2'h0) && ((plant_on && move === 1'b1) || nudge);
    step_dir <= nudge ? 1'b1 : dir;
    if (step === 1'b1)
      n_steps <= n_steps + 1;
    if (lnk.busy === 1'b1 && move === 1'b0)
      halts <= halts + 1;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // classic cycle: hold everything until ack is seen, release cyc and stb at the next edge after that
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_w <= d;
    sel <= s;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack !== 1'b1 && n < 50);
    q = dat_r;
    @(posedge clk_i);
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 50)
      chk(32'h0, 32'h1, "no ack");
  endtask

  task automatic wait_busy(input logic v);
    int n;
    n = 0;
    while (lnk.busy !== v && n < 2000)
    begin
      @(negedge clk_i);
      n++;
    end
    if (n >= 2000)
      chk(32'h0, 32'h1, "busy wait");
  endtask

  task automatic go(input logic [31:0] cmd);
    wb(1'b1, OFS_CTRL, cmd);
    wb(1'b1, OFS_CTRL, MODE);
  endtask

  task automatic setup(input logic [31:0] cfg);
    wb(1'b1, OFS_CFG, cfg);
    wb(1'b1, OFS_CTRL, MODE);
    repeat (6) @(posedge clk_i);
  endtask

  task automatic do_reset;
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
  endtask

  task automatic t_regs;
    wb(1'b0, 4'hc, 32'h0);
    chk(q, 32'h0, "unmapped read");
    wb(1'b1, OFS_CTRL, 32'h0000_0001);
    wb(1'b1, OFS_CFG, 32'h0000_004a);
    repeat (3) @(negedge clk_i);
    chk(32'({lnk.auto_manual_select, lnk.table_select, lnk.pos_speed_source_select}), 32'h201, "mode");
    chk(32'(lnk.home_method_param), 32'(METHOD_DOG_CRADLE), "method");
    wb(1'b0, OFS_STATUS, 32'h0);
    chk(32'(q[ST_HOME_EST]), 32'h1, "absolute home");
    wb(1'b1, OFS_CFG, 32'h0000_006a);
    repeat (3) @(negedge clk_i);
    chk(32'(lnk.position_system_param), 32'(SYSTEM_INCREMENTAL), "roll system");
    $display("test regs done");
  endtask

  task automatic t_gate;
    logic [31:0] m;
    for (int i = 0; i < 2; i++)
    begin
      m = (i == 0) ? (MODE | 32'h2) : MODE;
      wb(1'b1, OFS_CFG, (i == 0) ? 32'ha : 32'h9);
      wb(1'b1, OFS_CTRL, m);
      repeat (6) @(posedge clk_i);
      go(m | FWD);
      repeat (3) @(negedge clk_i);
      chk(32'(lnk.busy), 32'h0, "start ignored");
    end
    $display("test gate done");
  endtask

  task automatic t_home;
    int n0;
    setup(32'h0000_000a);
    go(FWD);
    wait_busy(1'b1);
    repeat (2) @(negedge clk_i);
    chk(32'({move, dir, spd}), 32'({2'b11, hspd}), "seek");
    chk({acc_o, dec_o}, {acc, dec}, "ramp");
    chk(dcur, cur, "display mirror");
    @(posedge clk_i);
    dog <= 1'b1;
    repeat (6) @(negedge clk_i);
    chk(32'(spd), 32'(cspd), "creep");
    @(posedge clk_i);
    zph <= 1'b1;
    @(posedge clk_i);
    zph <= 1'b0;
    n0 = n_steps;
    repeat (6) @(posedge clk_i);
    plant_on <= 1'b1;
    wait_busy(1'b0);
    chk(32'(n_steps - n0), 32'h3, "shift");
    chk(cur, HOME_VAL, "home load");
    chk(32'(lnk.home_established), 32'h1, "home set");
    @(posedge clk_i);
    plant_on <= 1'b0;
    dog <= 1'b0;
    $display("test home done");
  endtask

  task automatic t_auto;
    for (int i = 0; i < 2; i++)
    begin
      @(posedge clk_i);
      nudge <= 1'b1;
      repeat (20) @(posedge clk_i);
      nudge <= 1'b0;
      pmax <= (i == 0) ? 32'sh0000_03e8 : 32'sh0000_0065;
      go(REV);
      repeat (2) @(negedge clk_i);
      chk(32'(lnk.busy), 32'(i == 0), "auto start");
      if (i == 0)
      begin
        chk(32'({dir, spd}), 32'(hspd), "auto travel");
        @(posedge clk_i);
        plant_on <= 1'b1;
        wait_busy(1'b0);
        chk(cur, HOME_VAL, "auto arrive");
        @(posedge clk_i);
        plant_on <= 1'b0;
      end
    end
    wb(1'b0, OFS_STATUS, 32'h0);
    chk(32'(q[ST_REFUSED]), 32'h1, "refused flag");
    wb(1'b1, OFS_STATUS, 32'h8, 4'h1);
    wb(1'b0, OFS_STATUS, 32'h0);
    chk(32'(q[ST_REFUSED]), 32'h0, "refused clear");
    pmax <= 32'sh0000_03e8;
    $display("test auto done");
  endtask

  task automatic t_return;
    int h0;
    @(posedge clk_i);
    dog <= 1'b1;
    go(FWD);
    repeat (4) @(negedge clk_i);
    chk(32'({move, dir}), 32'h2, "back off");
    @(posedge clk_i);
    dog <= 1'b0;
    repeat (6) @(negedge clk_i);
    chk(32'({move, dir}), 32'h3, "seek after back off");
    @(posedge clk_i);
    fwd_end <= 1'b1;
    repeat (6) @(negedge clk_i);
    chk(32'({move, dir}), 32'h2, "reverse at end");
    @(posedge clk_i);
    fwd_end <= 1'b0;
    dog <= 1'b1;
    repeat (6) @(posedge clk_i);
    h0 = halts;
    dog <= 1'b0;
    repeat (8) @(negedge clk_i);
    chk(32'({move, dir, halts != h0}), 32'h7, "halt then seek");
    @(posedge clk_i);
    fwd_end <= 1'b1;
    repeat (6) @(posedge clk_i);
    fwd_end <= 1'b0;
    rev_end <= 1'b1;
    wait_busy(1'b0);
    wb(1'b0, OFS_STATUS, 32'h0);
    chk({q & 32'h0000_ff06} | 32'(move), 32'h0000_9004, "no dog alarm");
    @(posedge clk_i);
    rev_end <= 1'b0;
    $display("test return done");
  endtask

  task automatic t_roll;
    setup(32'h0000_002a);
    @(posedge clk_i);
    nudge <= 1'b1;
    repeat (12) @(posedge clk_i);
    nudge <= 1'b0;
    go(FWD);
    wait_busy(1'b1);
    @(negedge clk_i);
    chk(dcur | dcmd, 32'h0, "roll zero");
    $display("test roll done");
  endtask

  task automatic print_verdict;
    $display("counts: %0d mismatches, %0d comparisons", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // main sequence; resets follow the register test and the return test, with no motion running
  initial
  begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs;
    do_reset;
    t_gate;
    t_home;
    t_auto;
    t_return;
    do_reset;
    t_roll;
    print_verdict;
  end

  // the tests need a few hundred cycles; this leaves wide margin
  initial
  begin
    repeat (40000) @(posedge clk_i);
    errors++;
    print_verdict;
  end
endmodule
